// ---- rtl/tbwd_pkg.sv ----
package tbwd_pkg;

    // Register byte addresses.
    localparam logic [7:0] TB_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] WD_CTRL_ADDR   = 8'h04;
    localparam logic [7:0] WATCH_CTRL_ADDR = 8'h08;
    localparam logic [7:0] IRQ_STAT_ADDR  = 8'h0c;
    localparam logic [7:0] IRQ_MASK_ADDR  = 8'h10;
    localparam logic [7:0] TB_COUNT_ADDR  = 8'h14;
    localparam logic [7:0] WD_STAT_ADDR   = 8'h18;

    // Time-base control fields.
    localparam int TB_SEL_LO_BIT   = 0;
    localparam int TB_IRQ_EN_BIT   = 2;
    localparam int TB_OVF_BIT      = 3;
    localparam int TB_CLEAR_BIT    = 4;
    // Watchdog control fields.
    localparam int WD_SEL_LO_BIT   = 0;
    localparam int WD_ACTIVATE_BIT = 7;
    // Watch control field.
    localparam int WD_SRC_BIT      = 0;
    // Interrupt status bits.
    localparam int IRQ_TB_BIT      = 0;

    localparam int TB_WIDTH        = 18;
    localparam logic [7:0] TB_IRQ_NUMBER = 8'h10;

    // Time-base carry taps for the four interval choices (2^12,14,16,19 HCLK).
    localparam int TB_TAP0 = 10;
    localparam int TB_TAP1 = 12;
    localparam int TB_TAP2 = 14;
    localparam int TB_TAP3 = 17;
    // Watchdog time-base taps: 2^14,16,18,21 HCLK periods over 4 counts of 2 HCLK.
    localparam int WD_TB_TAP0 = 10;
    localparam int WD_TB_TAP1 = 12;
    localparam int WD_TB_TAP2 = 14;
    localparam int WD_TB_TAP3 = 17;
    // Watch timer taps: 2^12,15,16,17 sub-clock periods over 4 counts.
    localparam int WD_WT_TAP0 = 9;
    localparam int WD_WT_TAP1 = 12;
    localparam int WD_WT_TAP2 = 13;
    localparam int WD_WT_TAP3 = 14;

    localparam logic [1:0]  WD_COUNT_RESET = 2'h0;
    localparam logic [17:0] TB_COUNT_RESET = 18'h00000;

    // Bounds of the reset time, in nanoseconds.
    localparam real WD_MIN_TB_NS = 3580000.0;
    localparam real WD_MAX_TB_NS = 589820000.0;
    localparam real WD_MAX_SC_NS = 18432000000.0;

    typedef enum logic [1:0] {
        WD_OFF    = 2'b00,
        WD_ARMED  = 2'b01,
        WD_FIRED  = 2'b10
    } wd_state_t;

endpackage

// ---- rtl/timebase_and_watchdog_timer.sv ----
`timescale 1ns/1ps
// How it works
// - Eighteen-bit time-base counter counts up once per main clock (oscillator/2).
// - Carry of the selected interval bit sets the overflow flag and raises a request.
// - Overflow reaches the interrupt line only while the enable bit is one.
// - Four interval choices: 2^12, 2^14, 2^16, 2^19 oscillator periods.
// - Divided taps of the counter go to stabilisation timer and peripherals.
// - Time-base overflow is delivered as interrupt request number 16 (0x10).
// - Watchdog is a two-bit counter advanced by a time-base or watch-timer carry.
// - CPU reset is asserted when the interval passes without a clear.
// - A source bit in the watch control register picks time-base or watch carry.
// - A two-bit field in the watchdog control register picks one of four taps.
// - Reset falls between the documented minimum and maximum for each source.
// - Clearing the time-base counter restarts the watchdog's time-base clock source, not the watch timer.
// - The watch timer feeding the watchdog always counts on the sub clock.
module timebase_and_watchdog_timer
    import tbwd_pkg::*;
#(
    parameter int WT_WIDTH = 15
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset,
    // Main-clock and sub-clock count ticks, one cycle each.
    input  wire logic        mainTick,
    input  wire logic        subTick,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Interrupt and reset outputs.
    output logic             irq,
    output logic      [7:0]  irqNumber,
    output logic             cpuReset,
    // Divided clock taps.
    output logic      [TB_WIDTH-1:0] tbTaps
);
    import tbwd_pkg::*;

    typedef struct packed {
        logic [TB_WIDTH-1:0] tbCount;
        logic [WT_WIDTH-1:0] wtCount;
        logic [1:0]          tbSel;
        logic                tbIrqEnable;
        logic                tbOverflowFlag;
        logic [1:0]          wdSel;
        logic                wdSource;
        logic [1:0]          wdCount;
        wd_state_t           wdState;
        logic                irqStatus;
        logic                irqMask;
        logic                wrPending;
        logic [7:0]          wrAddr;
        logic [31:0]         rdata;
        logic                irq;
        logic                cpuReset;
        logic [TB_WIDTH-1:0] tbTaps;
    } state_t;

    state_t s;
    state_t next_s;

    logic tbCarry;
    logic wdTbCarry;
    logic wdWtCarry;
    logic wdAdvance;
    logic tbClear;
    logic wdClear;
    logic wdActivate;
    logic [TB_WIDTH-1:0] tbInc;
    logic [WT_WIDTH-1:0] wtInc;

    function automatic logic [TB_WIDTH-1:0] carryOut(
        input logic [TB_WIDTH-1:0] oldV, input logic [TB_WIDTH-1:0] newV);
        carryOut = oldV & ~newV;
    endfunction

    wire addrPhase = hsel && hready && htrans[1];

    always_comb begin
        logic [TB_WIDTH-1:0] tbFall;
        logic [WT_WIDTH-1:0] wtFall;
        next_s     = s;
        tbInc      = s.tbCount + TB_WIDTH'(1);
        wtInc      = s.wtCount + WT_WIDTH'(1);
        tbFall     = mainTick ? carryOut(s.tbCount, tbInc) : '0;
        wtFall     = subTick ? (s.wtCount & ~wtInc) : '0;
        tbClear    = 1'b0;
        wdClear    = 1'b0;
        wdActivate = 1'b0;

        // Write data phase.
        next_s.wrPending = addrPhase && hwrite;
        next_s.wrAddr    = haddr;
        if (s.wrPending) begin
            unique case (s.wrAddr)
                TB_CTRL_ADDR: begin
                    next_s.tbSel       = hwdata[TB_SEL_LO_BIT +: 2];
                    next_s.tbIrqEnable = hwdata[TB_IRQ_EN_BIT];
                    tbClear            = hwdata[TB_CLEAR_BIT];
                end
                WD_CTRL_ADDR: begin
                    next_s.wdSel = hwdata[WD_SEL_LO_BIT +: 2];
                    // A write with the activate bit arms an inactive watchdog or clears an armed one.
                    wdActivate   = hwdata[WD_ACTIVATE_BIT];
                    wdClear      = hwdata[WD_ACTIVATE_BIT];
                end
                WATCH_CTRL_ADDR: next_s.wdSource = hwdata[WD_SRC_BIT];
                IRQ_MASK_ADDR:   next_s.irqMask  = hwdata[IRQ_TB_BIT];
                default: ;
            endcase
        end

        // Time-base counter.
        next_s.tbCount = mainTick ? tbInc : s.tbCount;
        if (tbClear) begin
            next_s.tbCount = TB_COUNT_RESET;
        end
        // The watch timer runs on sub-clock ticks only.
        next_s.wtCount = subTick ? wtInc : s.wtCount;

        unique case (s.tbSel)
            2'h0: tbCarry = tbFall[TB_TAP0];
            2'h1: tbCarry = tbFall[TB_TAP1];
            2'h2: tbCarry = tbFall[TB_TAP2];
            default: tbCarry = tbFall[TB_TAP3];
        endcase
        unique case (s.wdSel)
            2'h0: begin
                wdTbCarry = tbFall[WD_TB_TAP0];
                wdWtCarry = wtFall[WD_WT_TAP0];
            end
            2'h1: begin
                wdTbCarry = tbFall[WD_TB_TAP1];
                wdWtCarry = wtFall[WD_WT_TAP1];
            end
            2'h2: begin
                wdTbCarry = tbFall[WD_TB_TAP2];
                wdWtCarry = wtFall[WD_WT_TAP2];
            end
            default: begin
                wdTbCarry = tbFall[WD_TB_TAP3];
                wdWtCarry = wtFall[WD_WT_TAP3];
            end
        endcase
        if (tbClear) begin
            tbCarry   = 1'b0;
            wdTbCarry = 1'b0;
        end

        // Overflow flag: set wins over a software clear in the same cycle.
        if (s.wrPending && s.wrAddr == TB_CTRL_ADDR && !hwdata[TB_OVF_BIT]) begin
            next_s.tbOverflowFlag = 1'b0;
        end
        if (s.wrPending && s.wrAddr == IRQ_STAT_ADDR && hwdata[IRQ_TB_BIT]) begin
            next_s.irqStatus = 1'b0;
        end
        if (tbCarry) begin
            next_s.tbOverflowFlag = 1'b1;
            next_s.irqStatus      = 1'b1;
        end

        // Watchdog: source 1 is the time-base carry, 0 the watch timer.
        wdAdvance = s.wdSource ? wdTbCarry : wdWtCarry;
        unique case (s.wdState)
            WD_OFF: begin
                if (wdActivate) begin
                    next_s.wdState = WD_ARMED;
                    next_s.wdCount = WD_COUNT_RESET;
                end
            end
            WD_ARMED: begin
                if (wdClear) begin
                    next_s.wdCount = WD_COUNT_RESET;
                end else if (wdAdvance) begin
                    // Fourth carry after a clear overflows the two-bit counter.
                    if (s.wdCount == 2'h3) begin
                        next_s.wdState = WD_FIRED;
                    end
                    next_s.wdCount = s.wdCount + 2'h1;
                end
            end
            WD_FIRED: next_s.wdState = WD_FIRED;
            default:  next_s.wdState = WD_OFF;
        endcase

        next_s.cpuReset = (next_s.wdState == WD_FIRED);
        // Flag is raised regardless of enable; the line is gated by it.
        next_s.irq      = next_s.tbOverflowFlag && next_s.tbIrqEnable
                          && next_s.irqStatus && next_s.irqMask;
        next_s.tbTaps   = next_s.tbCount;

        // Read data, registered for the data phase.
        next_s.rdata = 32'h00000000;
        if (addrPhase && !hwrite) begin
            unique case (haddr)
                TB_CTRL_ADDR: next_s.rdata = {27'h0, 1'b0, s.tbOverflowFlag,
                                              s.tbIrqEnable, s.tbSel};
                WD_CTRL_ADDR:    next_s.rdata = {30'h0, s.wdSel};
                WATCH_CTRL_ADDR: next_s.rdata = {31'h0, s.wdSource};
                IRQ_STAT_ADDR:   next_s.rdata = {31'h0, s.irqStatus};
                IRQ_MASK_ADDR:   next_s.rdata = {31'h0, s.irqMask};
                TB_COUNT_ADDR:   next_s.rdata = {14'h0, s.tbCount};
                WD_STAT_ADDR:    next_s.rdata = {28'h0, s.wdState, s.wdCount};
                default:         next_s.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata    = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = s.irq;
    assign irqNumber = TB_IRQ_NUMBER;
    assign cpuReset  = s.cpuReset;
    assign tbTaps    = s.tbTaps;

    sequence clearWrite;
        s.wrPending && s.wrAddr == WD_CTRL_ADDR && hwdata[WD_ACTIVATE_BIT];
    endsequence

    chk_tb_count_step: assert property (@(posedge clk) disable iff (reset)
        mainTick && !tbClear |=> s.tbCount == $past(s.tbCount) + TB_WIDTH'(1))
        else $error("time-base counter did not advance");
    chk_tb_flag_set: assert property (@(posedge clk) disable iff (reset)
        tbCarry |=> s.tbOverflowFlag)
        else $error("overflow flag not set on carry");
    chk_irq_gate: assert property (@(posedge clk) disable iff (reset)
        irq |-> s.tbIrqEnable && s.tbOverflowFlag)
        else $error("interrupt without enable");
    chk_flag_hold: assert property (@(posedge clk) disable iff (reset)
        s.tbOverflowFlag && !s.wrPending |=> s.tbOverflowFlag)
        else $error("overflow flag dropped without write");
    chk_wd_clear_zero: assert property (@(posedge clk) disable iff (reset)
        clearWrite ##0 (s.wdState == WD_ARMED) |=> s.wdCount == 2'h0)
        else $error("watchdog clear did not zero counter");
    chk_wd_idle_quiet: assert property (@(posedge clk) disable iff (reset)
        s.wdState == WD_OFF |-> !cpuReset)
        else $error("reset from inactive watchdog");
    chk_wd_fire: assert property (@(posedge clk) disable iff (reset)
        s.wdState == WD_ARMED && !wdClear && wdAdvance && s.wdCount == 2'h3
        |=> ##1 cpuReset)
        else $error("watchdog did not reset cpu");
    chk_tb_clear_restart: assert property (@(posedge clk) disable iff (reset)
        tbClear |=> s.tbCount == TB_COUNT_RESET)
        else $error("time-base clear ignored");
    chk_wd_source: assert property (@(posedge clk) disable iff (reset)
        !s.wdSource && !wdWtCarry |-> !wdAdvance)
        else $error("watchdog advanced from wrong source");

    // A watchdog step needs an armed counter and no clear in the same cycle.
    sequence armedNoClear;
        s.wdState == WD_ARMED && !wdClear;
    endsequence

    sequence tbSourceStep;
        s.wdSource && wdTbCarry;
    endsequence

    sequence wtSourceStep;
        !s.wdSource && wdWtCarry;
    endsequence

    sequence flagClearWrite;
        s.wrPending && s.wrAddr == TB_CTRL_ADDR && !hwdata[TB_OVF_BIT];
    endsequence

    sequence statusClearWrite;
        s.wrPending && s.wrAddr == IRQ_STAT_ADDR && hwdata[IRQ_TB_BIT];
    endsequence

    chk_wd_tb_step: assert property (@(posedge clk) disable iff (reset)
        armedNoClear ##0 tbSourceStep |=> s.wdCount == $past(s.wdCount) + 2'h1)
        else $error("watchdog missed a time-base carry");

    chk_wd_wt_step: assert property (@(posedge clk) disable iff (reset)
        armedNoClear ##0 wtSourceStep |=> s.wdCount == $past(s.wdCount) + 2'h1)
        else $error("watchdog missed a watch-timer carry");

    chk_flag_clear: assert property (@(posedge clk) disable iff (reset)
        flagClearWrite ##0 (!tbCarry) |=> !s.tbOverflowFlag)
        else $error("overflow flag not cleared by write");

    chk_status_clear: assert property (@(posedge clk) disable iff (reset)
        statusClearWrite ##0 (!tbCarry) |=> !s.irqStatus)
        else $error("status bit not cleared by write");

    chk_set_wins: assert property (@(posedge clk) disable iff (reset)
        flagClearWrite ##0 tbCarry |=> s.tbOverflowFlag)
        else $error("flag clear won over a carry");

    chk_tb_hold: assert property (@(posedge clk) disable iff (reset)
        !mainTick && !tbClear |=> $stable(s.tbCount))
        else $error("time-base counter moved without a tick");

    chk_wt_step: assert property (@(posedge clk) disable iff (reset)
        subTick |=> s.wtCount == $past(s.wtCount) + WT_WIDTH'(1))
        else $error("watch timer did not advance");

    chk_wt_hold: assert property (@(posedge clk) disable iff (reset)
        !subTick |=> $stable(s.wtCount))
        else $error("watch timer moved without a tick");

    chk_tap_follow: assert property (@(posedge clk) disable iff (reset)
        mainTick && !tbClear |=> tbTaps == $past(s.tbCount) + TB_WIDTH'(1))
        else $error("divided taps do not follow the counter");

    chk_irq_level: assert property (@(posedge clk) disable iff (reset)
        s.tbOverflowFlag && s.tbIrqEnable && s.irqStatus && s.irqMask |-> irq)
        else $error("enabled overflow did not raise the interrupt");

    chk_irq_number: assert property (@(posedge clk) disable iff (reset)
        irqNumber == TB_IRQ_NUMBER)
        else $error("wrong interrupt request number");

    chk_tb_tap_short: assert property (@(posedge clk) disable iff (reset)
        mainTick && !tbClear && s.tbSel == 2'h0 && &s.tbCount[TB_TAP0:0] |-> tbCarry)
        else $error("shortest interval carry missed");

    chk_tb_tap_long: assert property (@(posedge clk) disable iff (reset)
        mainTick && !tbClear && s.tbSel == 2'h3 && &s.tbCount[TB_TAP3:0] |-> tbCarry)
        else $error("longest interval carry missed");

    chk_wd_arm: assert property (@(posedge clk) disable iff (reset)
        s.wdState == WD_OFF && wdActivate |=> s.wdState == WD_ARMED)
        else $error("watchdog did not activate");

    chk_reset_sticky: assert property (@(posedge clk) disable iff (reset)
        cpuReset |=> cpuReset)
        else $error("cpu reset dropped before system reset");

    chk_off_count: assert property (@(posedge clk) disable iff (reset)
        s.wdState == WD_OFF |-> s.wdCount == WD_COUNT_RESET)
        else $error("inactive watchdog counter moved");
endmodule

// ---- verification/test_timebase_and_watchdog_timer.sv ----
`timescale 1ns/1ps
module test_timebase_and_watchdog_timer;
    import tbwd_pkg::*;
    localparam int SUB_DIV = 2;
    localparam int LIMIT   = 90000;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rdLate;
    logic        hreadyout, hresp, irq, cpuReset, mainTick, subTick;
    logic [7:0]  irqNumber;
    logic [17:0] tbTaps;
    int          errCount = 0;
    int          nTests = 0;
    int          cycles = 0;
    int          tapList[3] = '{TB_TAP0, TB_TAP1, TB_TAP2};

    always #5 clk = ~clk;
    // Read data is copied mid-cycle so the sampling edge never races the design.
    always @(negedge clk) rdLate = hrdata;
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errCount++;
            $display("MISMATCH %0t run did not finish", $time);
            results();
        end
    end

    tick_source #(.SUB_DIV(SUB_DIV)) ticks (.clk(clk), .reset(reset), .mainTick(mainTick),
        .subTick(subTick));
    timebase_and_watchdog_timer dut (.clk(clk), .reset(reset), .mainTick(mainTick),
        .subTick(subTick), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .irqNumber(irqNumber),
        .cpuReset(cpuReset), .tbTaps(tbTaps));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpRange(input int n, input int lo, input int hi);
        nTests++;
        if (n < lo || n > hi) begin
            errCount++;
            $display("MISMATCH %0t took %0d cycles, window %0d..%0d", $time, n, lo, hi);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = rdLate;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        cmp(q & m, exp);
    endtask

    // Counts falling edges until irq (or cpuReset) is seen high.
    task automatic waitFor(input logic useReset, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (((useReset ? cpuReset : irq) !== 1'b1) && n < LIMIT);
    endtask

    task automatic doReset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        cmp({14'h0, tbTaps}, {14'h0, TB_COUNT_RESET});
        cmp({31'h0, cpuReset}, 32'h0);
        @(posedge clk);
        reset <= 1'b0;
    endtask

    task automatic results();
        $display("mismatches %0d of %0d checks", errCount, nTests);
        if (errCount == 0 && nTests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        int n;
        int p;
        doReset();
        cmp({24'h0, irqNumber}, {24'h0, TB_IRQ_NUMBER});
        cmp({30'h0, hresp, hreadyout}, 32'h1);
        rdChk(8'h1c, 32'hffffffff, 32'h0);
        wr(8'h1c, 32'hffffffff);
        rdChk(8'h1c, 32'hffffffff, 32'h0);
        wr(IRQ_MASK_ADDR, 32'h1);
        rdChk(IRQ_MASK_ADDR, 32'h1, 32'h1);
        for (int s = 0; s < 3; s++) begin
            p = 1 << (tapList[s] + 1);
            wr(TB_CTRL_ADDR, (32'h1 << TB_CLEAR_BIT) | (32'h1 << TB_IRQ_EN_BIT) | s);
            wr(IRQ_STAT_ADDR, 32'h1);
            waitFor(1'b0, n);
            cmpRange(n, p - 12, p + 4);
            rdChk(TB_CTRL_ADDR, 32'h8, 32'h8);
            rdChk(IRQ_STAT_ADDR, 32'h1, 32'h1);
        end
        wr(TB_CTRL_ADDR, 32'h1 << TB_CLEAR_BIT);
        wr(IRQ_STAT_ADDR, 32'h1);
        repeat (2100) @(negedge clk);
        cmp({31'h0, irq}, 32'h0);
        rdChk(TB_CTRL_ADDR, 32'h8, 32'h8);
        wr(TB_CTRL_ADDR, 32'h0);
        rdChk(TB_CTRL_ADDR, 32'h8, 32'h0);
        wr(IRQ_MASK_ADDR, 32'h0);
        wr(TB_CTRL_ADDR, (32'h1 << TB_CLEAR_BIT) | (32'h1 << TB_IRQ_EN_BIT));
        wr(IRQ_STAT_ADDR, 32'h1);
        repeat (2100) @(negedge clk);
        cmp({31'h0, irq}, 32'h0);
        rdChk(IRQ_STAT_ADDR, 32'h1, 32'h1);
        wr(IRQ_MASK_ADDR, 32'h1);
        repeat (2) @(negedge clk);
        cmp({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_ADDR, 32'h1);
        repeat (2) @(negedge clk);
        cmp({31'h0, irq}, 32'h0);
        cmp({31'h0, cpuReset}, 32'h0);
        p = 1 << (WD_TB_TAP0 + 1);
        wr(WATCH_CTRL_ADDR, 32'h1);
        wr(WD_CTRL_ADDR, 32'h80);
        repeat (4) begin
            repeat (1500) @(posedge clk);
            wr(WD_CTRL_ADDR, 32'h80);
        end
        cmp({31'h0, cpuReset}, 32'h0);
        waitFor(1'b1, n);
        cmpRange(n, 3 * p - 4, 4 * p + 8);
        repeat (50) @(negedge clk);
        cmp({31'h0, cpuReset}, 32'h1);
        doReset();
        p = (1 << (WD_WT_TAP0 + 1)) * SUB_DIV;
        wr(WATCH_CTRL_ADDR, 32'h0);
        wr(WD_CTRL_ADDR, 32'h80);
        waitFor(1'b1, n);
        cmpRange(n, 3 * p - 4, 4 * p + 8);
        results();
    end
endmodule

// ---- verification/tick_source.sv ----
`timescale 1ns/1ps
module tick_source #(
    parameter int SUB_DIV = 2
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Count ticks.
    output logic      mainTick,
    output logic      subTick
);
    int subCount = 0;
    initial mainTick = 1'b0;
    initial subTick = 1'b0;
    // Main ticks every cycle keep the long intervals short enough to simulate.
    always @(posedge clk) begin
        if (reset) begin
            mainTick <= 1'b0;
            subTick  <= 1'b0;
            subCount <= 0;
        end else begin
            mainTick <= 1'b1;
            subTick  <= (subCount == SUB_DIV - 1);
            subCount <= (subCount == SUB_DIV - 1) ? 0 : subCount + 1;
        end
    end
endmodule
